/* verilog/sgal_pkg.sv */
// constants, types and the quarter-wave sine function of the gauge logic
// assumes nothing of its surroundings; used by every design file
package sgal_pkg;

    ////////////////////////////////////////////////////////////////////////
    // word layout
    localparam int CODE_W = 10;
    localparam int QUAD_W = 2;
    localparam int IDX_W  = 8;
    localparam int MAG_W  = 10;

    // reset values and full-scale magnitude
    localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
    localparam logic [MAG_W-1:0]  MAG_OFF  = 10'h000;
    localparam logic [MAG_W-1:0]  MAG_FULL = 10'h3ff;

    // bounds on cos^2 + sin^2 at full drive
    localparam logic [2*MAG_W:0] MAG_SQ_LO = 21'h0fb770;
    localparam logic [2*MAG_W:0] MAG_SQ_HI = 21'h102ca0;

    // quadrant taken from the two top code bits
    typedef enum logic [QUAD_W-1:0] {Q_FIRST, Q_SECOND, Q_THIRD, Q_FOURTH} sgal_quad_t;

    ////////////////////////////////////////////////////////////////////////
    // odd quintic for sin(pi/2*u), coefficients with 16 fraction bits
    localparam longint COEF_A1 = 64'sd102944;
    localparam longint COEF_A3 = 64'sd42334;
    localparam longint COEF_A5 = 64'sd5223;
    localparam int     T_W     = IDX_W + 1;
    localparam int     SH_1    = 4 * T_W;
    localparam int     SH_3    = 2 * T_W;
    localparam int     SH_OUT  = 16 + 5 * T_W - MAG_W;

    // sample sits half a step above the index boundary: u = (2*idx+1)/512
    function automatic logic [MAG_W-1:0] sgal_quarter_sine(input logic [IDX_W-1:0] idx);
        longint t;
        longint r;
        t = 64'({idx, 1'b1});
        r = ((COEF_A1 * t) <<< SH_1) - ((COEF_A3 * t * t * t) <<< SH_3) + COEF_A5 * t * t * t * t * t;
        r = r >>> SH_OUT;
        // clamp: the polynomial is nondecreasing, so clamping keeps order
        if (r > longint'(MAG_FULL)) begin
            return MAG_FULL;
        end
        return r[MAG_W-1:0];
    endfunction

endpackage

/* verilog/sgal_if.sv */
// carriers between the gauge core, its serial link and its quadrant selector
// assumes sgal_pkg is compiled first
interface sgal_link_if;
    logic                          cs;
    logic                          din;
    logic                          dout;
    logic [sgal_pkg::CODE_W-1:0]   word;
    modport link (input cs, input din, output dout, output word);
    modport core (output cs, output din, input dout, input word);
endinterface

////////////////////////////////////////////////////////////////////////////
interface sgal_coil_if;
    logic [sgal_pkg::CODE_W-1:0]   code;
    logic [sgal_pkg::MAG_W-1:0]    cos_mag;
    logic [sgal_pkg::MAG_W-1:0]    sin_mag;
    logic                          cos_neg;
    logic                          sin_neg;
    modport map  (input code, output cos_mag, output sin_mag, output cos_neg, output sin_neg);
    modport core (output code, input cos_mag, input sin_mag, input cos_neg, input sin_neg);
endinterface

/* verilog/sgal_link.sv */
// serial input shift register, clocked by the host's serial clock
// assumes chip select is set up to the serial clock and the clock idles
// while the reset is released
module sgal_link (
    input  wire logic   sclk,
    input  wire logic   rst_n,
    sgal_link_if.link   lk
);
    import sgal_pkg::*;

    typedef struct packed {
        logic [CODE_W-1:0] sreg;
    } sgal_link_st_t;

    sgal_link_st_t st_r;
    sgal_link_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // shift msb first while selected; idle select freezes the word
    always_comb begin
        st_nxt = st_r;
        if (lk.cs) begin
            st_nxt.sreg = {st_r.sreg[CODE_W-2:0], lk.din};
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{sreg: CODE_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // old word leaves on the chain output as the new one enters
    assign lk.dout = st_r.sreg[CODE_W-1];
    assign lk.word = st_r.sreg;

    ////////////////////////////////////////////////////////////////////////
    shift_in_a: assert property (
        @(posedge sclk) disable iff (!rst_n)
        lk.cs |=> st_r.sreg == {$past(st_r.sreg[CODE_W-2:0]), $past(lk.din)})
        else $error("shift register did not take the data bit");

    shift_hold_a: assert property (
        @(posedge sclk) disable iff (!rst_n)
        !lk.cs |=> $stable(st_r.sreg))
        else $error("shift register moved while deselected");

    chain_out_a: assert property (
        @(posedge sclk) disable iff (!rst_n)
        lk.cs |=> lk.dout == $past(st_r.sreg[CODE_W-2]))
        else $error("chain output is not the next bit of the held word");

endmodule

/* verilog/sgal_map.sv */
// quadrant selector: code to signed sine and cosine coil magnitudes
// assumes a registered code at its input; purely combinational
module sgal_map (
    sgal_coil_if.map   cl
);
    import sgal_pkg::*;

    sgal_quad_t          quad;
    logic [IDX_W-1:0]    idx;
    logic [MAG_W-1:0]    s_mag;
    logic [MAG_W-1:0]    c_mag;

    ////////////////////////////////////////////////////////////////////////
    // first-quadrant magnitudes; cosine is the mirrored index
    always_comb begin
        quad  = sgal_quad_t'(cl.code[CODE_W-1 -: QUAD_W]);
        idx   = cl.code[IDX_W-1:0];
        s_mag = sgal_quarter_sine(idx);
        c_mag = sgal_quarter_sine(~idx);
    end

    // steer magnitudes and polarity per quadrant
    always_comb begin
        case (quad)
            Q_FIRST: begin
                cl.cos_mag = c_mag;
                cl.sin_mag = s_mag;
                cl.cos_neg = 1'b0;
                cl.sin_neg = 1'b0;
            end
            Q_SECOND: begin
                cl.cos_mag = s_mag;
                cl.sin_mag = c_mag;
                cl.cos_neg = 1'b1;
                cl.sin_neg = 1'b0;
            end
            Q_THIRD: begin
                cl.cos_mag = c_mag;
                cl.sin_mag = s_mag;
                cl.cos_neg = 1'b1;
                cl.sin_neg = 1'b1;
            end
            default: begin
                cl.cos_mag = s_mag;
                cl.sin_mag = c_mag;
                cl.cos_neg = 1'b0;
                cl.sin_neg = 1'b1;
            end
        endcase
    end

endmodule

/* verilog/sgal_top.sv */
// serial gauge angle logic: serial link, angle latch and coil drive codes
// assumes MCLK at 200 MHz, SCLK from the host, CS meeting SPI setup to SCLK
// and held low at least four MCLK periods after each frame
//
// Overview of operation
// - ten-bit shift register fed from data input
// - separate ten-bit latch holds displayed angle
// - words pass through to next chained device
// - serial port compatible with SPI
// - angle linear in code, 1024 steps
// - code steps centred half a step up
// - coil drives follow cosine and sine
// - quadrant selector steers magnitude and polarity
// - angle never moves back as code rises
// - msb first, sampled on rising serial clock
// - shift only selected; select fall with CE high loads latch
// - previous word shifted out on data output
// - output enable low disables drive, flags low
module sgal_top (
    input  wire logic                      MCLK,
    input  wire logic                      ARST_N,
    input  wire logic                      CE,
    input  wire logic                      SCLK,
    input  wire logic                      CS,
    input  wire logic                      DATA_IN,
    input  wire logic                      OE,
    output logic                           DATA_OUT,
    output logic [sgal_pkg::MAG_W-1:0]     COS_MAG,
    output logic [sgal_pkg::MAG_W-1:0]     SIN_MAG,
    output logic                           COS_NEG,
    output logic                           SIN_NEG,
    output logic                           DRV_EN,
    output logic                           FAULT_FLAG_N_O,
    output logic                           FAULT_FLAG_N_OE
);
    import sgal_pkg::*;

    typedef struct packed {
        logic                cs_m;
        logic                cs_s;
        logic                cs_d;
        logic                oe_m;
        logic                oe_s;
        logic                valid;
        logic [CODE_W-1:0]   code;
        logic [MAG_W-1:0]    cos_mag;
        logic [MAG_W-1:0]    sin_mag;
        logic                cos_neg;
        logic                sin_neg;
        logic                drv_en;
        logic                fault_oe;
    } sgal_top_st_t;

    sgal_top_st_t    st_r;
    sgal_top_st_t    st_nxt;
    logic [1:0]      rst_sync_r;
    logic            rst_n;
    logic            cs_fall;
    logic            drive;

    sgal_link_if     lk ();
    sgal_coil_if     cl ();

    ////////////////////////////////////////////////////////////////////////
    // reset: asserted at once, released two MCLK edges later
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // link side: select is synchronous to the serial clock there, so the
    // pins go straight in; the link runs only on SCLK edges
    assign lk.cs  = CS;
    assign lk.din = DATA_IN;

    sgal_link u_link (
        .sclk  (SCLK),
        .rst_n (rst_n),
        .lk    (lk)
    );

    // chain output is the link's own flip-flop; the next device in the
    // chain samples it on the same serial clock
    assign DATA_OUT = lk.dout;

    ////////////////////////////////////////////////////////////////////////
    // quadrant selector works on the latched code only, so a frame in
    // flight never disturbs the displayed angle
    assign cl.code = st_r.code;

    sgal_map u_map (
        .cl (cl)
    );

    ////////////////////////////////////////////////////////////////////////
    // falling select seen past the synchroniser; the link word is quiet
    // from then on because shifting needs select high, so it is safe to
    // take across the domains without further handshake
    assign cs_fall = st_r.cs_d & ~st_r.cs_s;

    // drive only after the first load and while enabled
    assign drive = st_r.valid & st_r.oe_s;

    // next state; CE low holds every field, the select synchroniser too,
    // so a frame that starts and ends inside a freeze is never seen and
    // the latch keeps its old word: the host must resend after a freeze
    always_comb begin
        st_nxt = st_r;
        if (CE) begin
            st_nxt.cs_m = CS;
            st_nxt.cs_s = st_r.cs_m;
            st_nxt.cs_d = st_r.cs_s;
            st_nxt.oe_m = OE;
            st_nxt.oe_s = st_r.oe_m;
            if (cs_fall) begin
                st_nxt.code  = lk.word;
                st_nxt.valid = 1'b1;
            end
            st_nxt.drv_en = drive;
            // disabled drivers show zero magnitude rather than stale codes
            st_nxt.cos_mag  = drive ? cl.cos_mag : MAG_OFF;
            st_nxt.sin_mag  = drive ? cl.sin_mag : MAG_OFF;
            st_nxt.cos_neg  = drive & cl.cos_neg;
            st_nxt.sin_neg  = drive & cl.sin_neg;
            st_nxt.fault_oe = ~drive;
        end
    end

    // state register; status pulls low from reset onward
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{code: CODE_RST, cos_mag: MAG_OFF, sin_mag: MAG_OFF, fault_oe: 1'b1, default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign COS_MAG         = st_r.cos_mag;
    assign SIN_MAG         = st_r.sin_mag;
    assign COS_NEG         = st_r.cos_neg;
    assign SIN_NEG         = st_r.sin_neg;
    assign DRV_EN          = st_r.drv_en;
    // open drain: only ever pulls low, so the data bit stays zero
    assign FAULT_FLAG_N_O  = 1'b0;
    assign FAULT_FLAG_N_OE = st_r.fault_oe;

    ////////////////////////////////////////////////////////////////////////
    // checks on the latch and the drive
    logic [2*MAG_W:0]   mag_sq;

    assign mag_sq = {1'b0, MAG_W'(0), st_r.cos_mag} * {1'b0, MAG_W'(0), st_r.cos_mag}
                  + {1'b0, MAG_W'(0), st_r.sin_mag} * {1'b0, MAG_W'(0), st_r.sin_mag};

    latch_load_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE && cs_fall |=> st_r.code == $past(lk.word) && st_r.valid)
        else $error("select fall did not load the latch");

    latch_hold_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        !(CE && cs_fall) |=> $stable(st_r.code))
        else $error("latch changed without a select fall");

    coil_follow_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE && drive |=> COS_MAG == $past(cl.cos_mag) && SIN_MAG == $past(cl.sin_mag) && DRV_EN)
        else $error("coil magnitudes do not follow the latched code");

    field_const_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        DRV_EN |-> mag_sq >= MAG_SQ_LO && mag_sq <= MAG_SQ_HI)
        else $error("field magnitude out of range");

    quad_sign_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE && drive |=> COS_NEG == ($past(st_r.code[CODE_W-1]) ^ $past(st_r.code[CODE_W-2]))
                     && SIN_NEG == $past(st_r.code[CODE_W-1]))
        else $error("coil polarity wrong for the quadrant");

    step_mono_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        st_r.code[IDX_W-1:0] != 8'hff |->
            sgal_quarter_sine(st_r.code[IDX_W-1:0] + 8'h01) >= sgal_quarter_sine(st_r.code[IDX_W-1:0]))
        else $error("quarter wave not monotonic");

    half_step_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        st_r.code == CODE_RST |-> cl.sin_mag != MAG_OFF && cl.cos_mag > cl.sin_mag && !cl.sin_neg)
        else $error("code zero not half a step above zero angle");

    quad_index_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        st_r.code[CODE_W-1 -: QUAD_W] == 2'h1 |->
            cl.sin_mag == sgal_quarter_sine(~st_r.code[IDX_W-1:0]) && cl.cos_neg)
        else $error("second quadrant not mirrored");

    oe_off_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE && !st_r.oe_s |=> !DRV_EN && FAULT_FLAG_N_OE && COS_MAG == MAG_OFF && SIN_MAG == MAG_OFF)
        else $error("drive not off while output enable low");

    reset_off_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        !st_r.valid |-> !DRV_EN && FAULT_FLAG_N_OE && st_r.code == CODE_RST)
        else $error("drive on before the first load");

    ////////////////////////////////////////////////////////////////////////
    // further checks on synchronisers, freeze, status and quadrants

    // internal reset leaves only through the second stage
    rst_sync_a: assert property (
        @(posedge MCLK) disable iff (!ARST_N)
        rst_sync_r[0] |=> rst_n)
        else $error("reset release skipped a stage");

    // select passes both stages before the fall detector reads it
    cs_sync_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE |=> st_r.cs_s == $past(st_r.cs_m) && st_r.cs_d == $past(st_r.cs_s))
        else $error("select synchroniser skipped a stage");

    // output enable passes both stages before it gates the drive
    oe_sync_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE |=> st_r.oe_s == $past(st_r.oe_m))
        else $error("enable synchroniser skipped a stage");

    // a frozen core keeps every field, the latch included
    freeze_hold_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        !CE |=> $stable(st_r))
        else $error("state moved while clock enable low");

    // one select fall loads the latch exactly once
    load_once_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE && cs_fall |=> !cs_fall)
        else $error("select fall seen twice");

    // the first load arms the drive a cycle later, never at once
    first_load_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE && cs_fall && !st_r.valid |=> st_r.valid && !DRV_EN)
        else $error("drive on in the cycle of the first load");

    // loaded and enabled: drivers on and status released
    drive_on_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        CE && st_r.valid && st_r.oe_s |=> DRV_EN && !FAULT_FLAG_N_OE)
        else $error("drive off although loaded and enabled");

    // status pulls low exactly while the drivers are off
    status_pair_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        FAULT_FLAG_N_OE != DRV_EN)
        else $error("status and drive enable disagree");

    // disabled drivers show neither magnitude nor polarity
    off_zero_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        !DRV_EN |-> COS_MAG == MAG_OFF && SIN_MAG == MAG_OFF && !COS_NEG && !SIN_NEG)
        else $error("disabled drivers show a drive value");

    // first quadrant: both coils positive, cosine on the mirrored index
    quad_first_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        st_r.code[CODE_W-1 -: QUAD_W] == 2'h0 |->
            cl.cos_mag == sgal_quarter_sine(~st_r.code[IDX_W-1:0])
            && cl.sin_mag == sgal_quarter_sine(st_r.code[IDX_W-1:0]) && !cl.cos_neg && !cl.sin_neg)
        else $error("first quadrant steered wrongly");

    // second quadrant: cosine takes the sine magnitude, sine positive
    quad_second_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        st_r.code[CODE_W-1 -: QUAD_W] == 2'h1 |->
            cl.cos_mag == sgal_quarter_sine(st_r.code[IDX_W-1:0]) && !cl.sin_neg)
        else $error("second quadrant cosine not swapped");

    // third quadrant: both coils negative, magnitudes as in the first
    quad_third_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        st_r.code[CODE_W-1 -: QUAD_W] == 2'h2 |->
            cl.cos_mag == sgal_quarter_sine(~st_r.code[IDX_W-1:0])
            && cl.sin_mag == sgal_quarter_sine(st_r.code[IDX_W-1:0]) && cl.cos_neg && cl.sin_neg)
        else $error("third quadrant steered wrongly");

    // fourth quadrant: cosine positive on the sine magnitude, sine negative
    quad_fourth_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        st_r.code[CODE_W-1 -: QUAD_W] == 2'h3 |->
            cl.cos_mag == sgal_quarter_sine(st_r.code[IDX_W-1:0])
            && cl.sin_mag == sgal_quarter_sine(~st_r.code[IDX_W-1:0]) && !cl.cos_neg && cl.sin_neg)
        else $error("fourth quadrant steered wrongly");

    // all ones sits half a step below a full turn
    full_scale_a: assert property (
        @(posedge MCLK) disable iff (!rst_n)
        st_r.code == '1 |-> cl.cos_mag > cl.sin_mag && cl.sin_mag != MAG_OFF && cl.sin_neg && !cl.cos_neg)
        else $error("all-ones code not half a step below full turn");

endmodule

/* sim/sgal_host.sv */
// host side of the serial link: an spi-style master clocking words in
// assumes one gauge device on the far side; the bench calls frame()
module sgal_host (
    output logic        SCLK,
    output logic        CS,
    output logic        DATA_IN,
    input  wire logic   DATA_OUT
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////
    // serial clock idles low between frames; data idles as the inverse
    initial begin
        SCLK    = 1'b0;
        CS      = 1'b0;
        DATA_IN = 1'b0;
    end

    // one frame of 20 bits, msb first, 160 ns serial period
    // the odd start offset keeps serial edges off the core clock phase
    task automatic frame(input logic sel, input logic [19:0] bits, output logic [19:0] seen);
        int i;
        #37.3;
        CS = sel;
        for (i = 19; i >= 0; i--) begin
            DATA_IN = bits[i];
            #80;
            seen[i] = DATA_OUT;
            SCLK = 1'b1;
            #80;
            SCLK = 1'b0;
        end
        #40;
        CS = 1'b0;
        DATA_IN = ~DATA_IN; // released line must not look like held data
    endtask
endmodule

/* sim/tb_serial_gauge_angle_logic.sv */
// self-checking bench for the gauge angle logic top
// assumes the host model in sgal_host and the design package sgal_pkg
module tb_serial_gauge_angle_logic;
    timeunit 1ns;
    timeprecision 100ps;
    import sgal_pkg::*;

    logic              MCLK, ARST_N, CE, OE, SCLK, CS, DATA_IN, DATA_OUT;
    logic [MAG_W-1:0]  COS_MAG, SIN_MAG;
    logic              COS_NEG, SIN_NEG, DRV_EN, FAULT_FLAG_N_O, FAULT_FLAG_N_OE;
    int                n_mismatch = 0;
    int                checks = 0;
    logic [9:0]        shreg = 10'h000;
    real               last_ang;

    sgal_top u_sgal_top (.MCLK(MCLK), .ARST_N(ARST_N), .CE(CE), .SCLK(SCLK), .CS(CS), .DATA_IN(DATA_IN),
        .OE(OE), .DATA_OUT(DATA_OUT), .COS_MAG(COS_MAG), .SIN_MAG(SIN_MAG), .COS_NEG(COS_NEG),
        .SIN_NEG(SIN_NEG), .DRV_EN(DRV_EN), .FAULT_FLAG_N_O(FAULT_FLAG_N_O), .FAULT_FLAG_N_OE(FAULT_FLAG_N_OE));
    sgal_host u_sgal_host (.SCLK(SCLK), .CS(CS), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT));

    ////////////////////////////////////////////////////////////////////////
    // compare helpers; the tolerance covers the polynomial's few-lsb error
    task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_near(input string nm, input int exp, input logic [9:0] got);
        checks++;
        if ((^got === 1'bx) || (int'(got) - exp > 4) || (exp - int'(got) > 4)) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // quarter-wave sample half a step above the index boundary
    function automatic int qsin(input logic [7:0] k);
        real v;
        v = $sin(3.14159265358979 * (2.0 * k + 1.0) / 1024.0) * 1024.0;
        return (v > 1023.0) ? 1023 : int'(v);
    endfunction

    task automatic chk_drive(input logic [9:0] code, input bit mono);
        int          s;
        int          c;
        real         a;
        real         e;
        logic [20:0] sq;
        s = qsin(code[7:0]);
        c = qsin(~code[7:0]);
        chk("drv_en", 20'h1, DRV_EN);
        chk("fault_oe", 20'h0, FAULT_FLAG_N_OE);
        chk("cos_neg", code[9] ^ code[8], COS_NEG);
        chk("sin_neg", code[9], SIN_NEG);
        chk_near("cos_mag", code[8] ? s : c, COS_MAG);
        chk_near("sin_mag", code[8] ? c : s, SIN_MAG);
        sq = COS_MAG * COS_MAG + SIN_MAG * SIN_MAG;
        chk("mag_sq_in_range", 20'h1, (sq >= MAG_SQ_LO) && (sq <= MAG_SQ_HI));
        a = $atan2(SIN_NEG ? -real'(SIN_MAG) : real'(SIN_MAG), COS_NEG ? -real'(COS_MAG) : real'(COS_MAG));
        a = a * 57.2957795;
        if (a < 0.0) begin
            a = a + 360.0;
        end
        e = (code + 0.5) * 360.0 / 1024.0;
        chk("angle_near", 20'h1, (a - e < 0.5) && (e - a < 0.5));
        if (mono) begin
            chk("angle_order", 20'h1, a >= last_ang);
        end
        last_ang = a;
    endtask

    // one 20-bit frame: first word passes through, second word stays
    task automatic send(input logic sel, input logic [9:0] a, input logic [9:0] b);
        logic [19:0] seen;
        u_sgal_host.frame(sel, {a, b}, seen);
        if (sel) begin
            chk("chain_out", {shreg, a}, seen);
            shreg = b;
        end else begin
            chk("idle_out", {20{shreg[9]}}, seen);
        end
        repeat (8) @(posedge MCLK);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk("drv_en_rst", 20'h0, DRV_EN);
        chk("mags_rst", 20'h0, {COS_MAG, SIN_MAG});
        chk("fault_oe_rst", 20'h1, FAULT_FLAG_N_OE);
        chk("fault_o_rst", 20'h0, FAULT_FLAG_N_O);
        chk("dout_rst", 20'h0, DATA_OUT);
    endtask

    task automatic t_quad();
        logic [9:0] codes [8] = '{10'h000, 10'h0ff, 10'h100, 10'h1c3, 10'h200, 10'h2a5, 10'h300, 10'h3ff};
        foreach (codes[i]) begin
            send(1'b1, ~codes[i], codes[i]);
            chk_drive(codes[i], 1'b0);
        end
    endtask

    task automatic t_sweep();
        last_ang = -1.0;
        for (int c = 10'h0fc; c <= 10'h104; c++) begin
            send(1'b1, 10'h155, 10'(c));
            chk_drive(10'(c), 1'b1);
        end
    endtask

    // clocking with select low must leave register and outputs alone
    task automatic t_unsel();
        send(1'b0, 10'h2aa, 10'h155);
        chk_drive(10'h104, 1'b0);
    endtask

    task automatic t_oe();
        @(posedge MCLK);
        #1 OE = 1'b0;
        repeat (4) @(posedge MCLK);
        #1;
        chk("drv_off", 20'h0, {DRV_EN, COS_NEG, SIN_NEG});
        chk("mags_off", 20'h0, {COS_MAG, SIN_MAG});
        chk("fault_oe_off", 20'h1, FAULT_FLAG_N_OE);
        OE = 1'b1;
        repeat (4) @(posedge MCLK);
        #1;
        chk_drive(10'h104, 1'b0);
    endtask

    // a frame wholly inside a freeze is lost: the core never sees the
    // select, so the latch keeps its word until the next frame
    task automatic t_ce();
        @(posedge MCLK);
        #1 CE = 1'b0;
        send(1'b1, 10'h3c0, 10'h2e7);
        chk_drive(10'h104, 1'b0);
        CE = 1'b1;
        repeat (6) @(posedge MCLK);
        #1;
        chk_drive(10'h104, 1'b0);
        send(1'b1, 10'h0aa, 10'h2e7);
        chk_drive(10'h2e7, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock, verdict, watchdog and main sequence
    always #2.5 MCLK = ~MCLK;

    task automatic conclude();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // about twenty frames of 3.3 us each; allow a wide margin
    initial begin
        #300000;
        n_mismatch++;
        conclude();
    end

    initial begin
        MCLK   = 1'b0;
        ARST_N = 1'b0;
        CE     = 1'b1;
        OE     = 1'b1;
        repeat (8) @(posedge MCLK);
        #1 ARST_N = 1'b1;
        repeat (4) @(posedge MCLK);
        #1;
        t_reset();
        t_quad();
        t_sweep();
        t_unsel();
        t_oe();
        t_ce();
        conclude();
    end
endmodule
